// File: hdl/can_chan_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module can_chan_ctrl #(
   parameter int BRP_MAX = 256,
   parameter int SEG_MAX = 8,
   parameter int PH2_MIN = 2,
   parameter int SJW_MAX = 4
) (
   // Clock and reset
   input  wire  logic        clk,
   input  wire  logic        nrst,
   // AXI4-Lite write
   input  wire  logic [7:0]  awaddr,
   input  wire  logic        awvalid,
   output var   logic        awready,
   input  wire  logic [31:0] wdata,
   input  wire  logic [3:0]  wstrb,
   input  wire  logic        wvalid,
   output var   logic        wready,
   output var   logic [1:0]  bresp,
   output var   logic        bvalid,
   input  wire  logic        bready,
   // AXI4-Lite read
   input  wire  logic [7:0]  araddr,
   input  wire  logic        arvalid,
   output var   logic        arready,
   output var   logic [31:0] rdata,
   output var   logic [1:0]  rresp,
   output var   logic        rvalid,
   input  wire  logic        rready,
   // Protocol core
   input  wire  logic        tx_bit,
   input  wire  logic        ack_drive,
   input  wire  logic        err_event,
   input  wire  logic        ok_event,
   output var   logic        rx_bit,
   output var   logic        sample_pulse,
   output var   logic        bit_start,
   output var   logic [4:0]  chan_state,
   output var   logic        irq,
   // Transceiver
   input  wire  logic        can_rx,
   output var   logic        can_tx
);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic reg_known(input logic [7:0] a);
      return a == can_chan_pkg::OFS_CTRL || a == can_chan_pkg::OFS_TIMING ||
             a == can_chan_pkg::OFS_STATUS || a == can_chan_pkg::OFS_INT_STS ||
             a == can_chan_pkg::OFS_INT_MSK;
   endfunction : reg_known

   function automatic logic timing_ok(input logic [31:0] t);
      logic [8:0]  b;
      logic [3:0]  pr;
      logic [3:0]  p1;
      logic [3:0]  p2;
      logic [2:0]  sj;
      logic [4:0]  t1;
      logic [14:0] cyc;
      b   = t[can_chan_pkg::TIM_BRP +: 9];
      pr  = t[can_chan_pkg::TIM_PROP +: 4];
      p1  = t[can_chan_pkg::TIM_PH1 +: 4];
      p2  = t[can_chan_pkg::TIM_PH2 +: 4];
      sj  = t[can_chan_pkg::TIM_SJW +: 3];
      t1  = {1'b0, pr} + {1'b0, p1};
      cyc = 15'(b) * (15'(t1) + 15'(p2) + 15'h1);
      return b >= 9'h1 && 32'(b) <= BRP_MAX &&
             p1 >= 4'h1 && 32'(p1) <= SEG_MAX &&
             32'(p2) >= PH2_MIN && 32'(p2) <= SEG_MAX &&
             pr >= 4'h1 && 32'(pr) <= SEG_MAX &&
             sj >= 3'h1 && 32'(sj) <= SJW_MAX &&
             32'(t1) >= can_chan_pkg::TS1_MIN &&
             32'(cyc) >= can_chan_pkg::BIT_CYC_MIN &&
             32'(cyc) <= can_chan_pkg::BIT_CYC_MAX;
   endfunction : timing_ok

   // Bus slave state
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic [7:0]  ar_addr_reg;
   logic        do_write;
   logic [31:0] w_merged;
   // Registers
   logic        en_reg;
   logic        listen_reg;
   logic        sleep_reg;
   logic        chan_rst_reg;
   logic [31:0] tim_reg;
   logic        tim_apply_reg;
   logic        tim_wr;
   logic        tim_good;
   localparam int INT_W_L = can_chan_pkg::INT_W;
   logic [INT_W_L-1:0] int_sts_reg;
   logic [INT_W_L-1:0] int_msk_reg;
   logic [INT_W_L-1:0] int_set;
   logic [INT_W_L-1:0] int_clr;
   // Fault confinement
   logic [8:0]  cnt_reg;
   logic        boff_reg;
   logic        run;
   can_chan_pkg::chan_state_e state_reg;
   can_chan_pkg::chan_state_e state_next;
   // Bit timing
   logic        rx_s1_reg;
   logic        rx_s2_reg;
   logic        rx_s3_reg;
   logic [8:0]  pre_reg;
   logic        tq_tick;
   logic [5:0]  q_reg;
   logic [5:0]  lng_reg;
   logic        edge_pend_reg;
   logic        synced_reg;
   logic [8:0]  brp_v;
   logic [5:0]  ts1;
   logic [5:0]  ts2;
   logic [5:0]  sjw;
   logic [5:0]  samp_at;
   logic [5:0]  last_q;
   logic        eng_clr;

   assign do_write = !awready && !wready && !bvalid;
   assign w_merged = merge(tim_reg, w_data_reg, w_strb_reg);
   assign tim_wr   = do_write && aw_addr_reg == can_chan_pkg::OFS_TIMING;
   assign tim_good = timing_ok(w_merged & can_chan_pkg::TIM_MASK);
   assign run      = en_reg && !sleep_reg;

   // Write channel: address and data taken independently
   always_ff @(posedge clk) begin
      if (!nrst) begin
         awready     <= 1'b1;
         wready      <= 1'b1;
         bvalid      <= 1'b0;
         bresp       <= can_chan_pkg::RESP_OKAY;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_addr_reg <= awaddr;
            awready     <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
            wready     <= 1'b0;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= reg_known(aw_addr_reg) ? can_chan_pkg::RESP_OKAY
                                             : can_chan_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Read channel: one cycle from address to data
   always_ff @(posedge clk) begin
      if (!nrst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= can_chan_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= reg_known(araddr) ? can_chan_pkg::RESP_OKAY : can_chan_pkg::RESP_SLVERR;
         case (araddr)
            can_chan_pkg::OFS_CTRL: begin
               rdata <= 32'({sleep_reg, 1'b0, listen_reg, en_reg});
            end
            can_chan_pkg::OFS_TIMING: begin
               rdata <= tim_reg;
            end
            can_chan_pkg::OFS_STATUS: begin
               rdata <= 32'({cnt_reg, 3'h0, state_reg});
            end
            can_chan_pkg::OFS_INT_STS: begin
               rdata <= 32'(int_sts_reg);
            end
            can_chan_pkg::OFS_INT_MSK: begin
               rdata <= 32'(int_msk_reg);
            end
            default: begin
               rdata <= 32'h0000_0000;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Control register; the reset bit is a one-shot and reads back zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         en_reg       <= 1'b0;
         listen_reg   <= 1'b0;
         sleep_reg    <= 1'b0;
         chan_rst_reg <= 1'b0;
      end else begin
         chan_rst_reg <= 1'b0;
         if (do_write && aw_addr_reg == can_chan_pkg::OFS_CTRL && w_strb_reg[0]) begin
            en_reg       <= w_data_reg[can_chan_pkg::CTRL_EN];
            listen_reg   <= w_data_reg[can_chan_pkg::CTRL_LISTEN];
            sleep_reg    <= w_data_reg[can_chan_pkg::CTRL_SLEEP];
            chan_rst_reg <= w_data_reg[can_chan_pkg::CTRL_RST];
         end
      end
   end

   // A rejected setting leaves the running timing untouched
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tim_reg       <= can_chan_pkg::TIM_RESET;
         tim_apply_reg <= 1'b0;
      end else begin
         tim_apply_reg <= tim_wr && tim_good;
         if (tim_wr && tim_good) begin
            tim_reg <= w_merged & can_chan_pkg::TIM_MASK;
         end
      end
   end

   // Sticky events; a set in the same cycle as its clear wins
   always_comb begin
      int_set = '0;
      int_set[can_chan_pkg::INT_WARN] = state_next == can_chan_pkg::ST_WARNING &&
                                        state_reg != can_chan_pkg::ST_WARNING;
      int_set[can_chan_pkg::INT_PASS] = state_next == can_chan_pkg::ST_PASSIVE &&
                                        state_reg != can_chan_pkg::ST_PASSIVE;
      int_set[can_chan_pkg::INT_BOFF] = state_next == can_chan_pkg::ST_BUSOFF &&
                                        state_reg != can_chan_pkg::ST_BUSOFF;
      int_set[can_chan_pkg::INT_REJECT] = tim_wr && !tim_good;
      int_clr = '0;
      if (do_write && aw_addr_reg == can_chan_pkg::OFS_INT_STS && w_strb_reg[0]) begin
         int_clr = w_data_reg[INT_W_L-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         int_sts_reg <= '0;
         int_msk_reg <= '0;
         irq         <= 1'b0;
      end else begin
         int_sts_reg <= (int_sts_reg & ~int_clr) | int_set;
         irq         <= |(int_sts_reg & int_msk_reg);
         if (do_write && aw_addr_reg == can_chan_pkg::OFS_INT_MSK && w_strb_reg[0]) begin
            int_msk_reg <= w_data_reg[INT_W_L-1:0];
         end
      end
   end

   // Error counter; bus-off holds until a channel reset
   always_ff @(posedge clk) begin
      if (!nrst || chan_rst_reg) begin
         cnt_reg  <= 9'h000;
         boff_reg <= 1'b0;
      end else begin
         if (err_event && cnt_reg <= 9'h1ff - 9'(can_chan_pkg::ERR_STEP)) begin
            cnt_reg <= cnt_reg + 9'(can_chan_pkg::ERR_STEP);
         end else if (ok_event && cnt_reg != 9'h000 && !boff_reg) begin
            cnt_reg <= cnt_reg - 9'h001;
         end
         if (run && 32'(cnt_reg) > can_chan_pkg::BUSOFF_ABOVE) begin
            boff_reg <= 1'b1;
         end
      end
   end

   always_comb begin
      if (!run) begin
         state_next = can_chan_pkg::ST_INACTIVE;
      end else if (boff_reg || 32'(cnt_reg) > can_chan_pkg::BUSOFF_ABOVE) begin
         state_next = can_chan_pkg::ST_BUSOFF;
      end else if (32'(cnt_reg) >= can_chan_pkg::PASSIVE_LEVEL) begin
         state_next = can_chan_pkg::ST_PASSIVE;
      end else if (32'(cnt_reg) >= can_chan_pkg::WARN_LEVEL) begin
         state_next = can_chan_pkg::ST_WARNING;
      end else begin
         state_next = can_chan_pkg::ST_ACTIVE;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg  <= can_chan_pkg::ST_INACTIVE;
         chan_state <= 5'h01;
      end else begin
         state_reg  <= state_next;
         chan_state <= state_next;
      end
   end

   // Transmit gate: off, bus-off and observer mode all stay recessive
   always_ff @(posedge clk) begin
      if (!nrst) begin
         can_tx <= 1'b1;
      end else if (!run || boff_reg || listen_reg) begin
         can_tx <= 1'b1;
      end else begin
         can_tx <= tx_bit && !ack_drive;
      end
   end

   // Receive pin synchroniser; third stage only for edge detection
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
         rx_s3_reg <= 1'b1;
      end else begin
         rx_s1_reg <= can_rx;
         rx_s2_reg <= rx_s1_reg;
         rx_s3_reg <= rx_s2_reg;
      end
   end

   assign brp_v   = tim_reg[can_chan_pkg::TIM_BRP +: 9];
   assign ts1     = 6'(tim_reg[can_chan_pkg::TIM_PROP +: 4]) +
                    6'(tim_reg[can_chan_pkg::TIM_PH1 +: 4]);
   assign ts2     = 6'(tim_reg[can_chan_pkg::TIM_PH2 +: 4]);
   assign sjw     = 6'(tim_reg[can_chan_pkg::TIM_SJW +: 3]);
   // Quantum 0 is the sync segment, so one bit spans 1+ts1+ts2 quanta
   assign samp_at = ts1 + lng_reg;
   assign last_q  = ts1 + ts2 + lng_reg;
   assign eng_clr = !run || chan_rst_reg || tim_apply_reg;
   assign tq_tick = pre_reg == brp_v - 9'h001;

   always_ff @(posedge clk) begin
      if (!nrst || eng_clr || tq_tick) begin
         pre_reg <= 9'h000;
      end else begin
         pre_reg <= pre_reg + 9'h001;
      end
   end

   // Resync: an edge in segment 1 lengthens it, in segment 2 cuts the bit short
   always_ff @(posedge clk) begin
      if (!nrst || eng_clr) begin
         q_reg         <= 6'h00;
         lng_reg       <= 6'h00;
         edge_pend_reg <= 1'b0;
         synced_reg    <= 1'b0;
         sample_pulse  <= 1'b0;
         bit_start     <= 1'b0;
         rx_bit        <= 1'b1;
      end else begin
         sample_pulse <= 1'b0;
         bit_start    <= 1'b0;
         if (tq_tick) begin
            edge_pend_reg <= 1'b0;
            // An edge in the sample quantum moves the sample point instead
            if (q_reg == samp_at && !edge_pend_reg) begin
               sample_pulse <= 1'b1;
               rx_bit       <= rx_s2_reg;
            end
            if (edge_pend_reg && q_reg != 6'h00 && q_reg <= samp_at) begin
               lng_reg    <= (q_reg < sjw) ? q_reg : sjw;
               synced_reg <= 1'b1;
               q_reg      <= q_reg + 6'h01;
            end else if (edge_pend_reg && q_reg > samp_at && last_q - q_reg > sjw) begin
               synced_reg <= 1'b1;
               q_reg      <= q_reg + sjw + 6'h01;
            end else if (q_reg == last_q || (edge_pend_reg && q_reg > samp_at)) begin
               q_reg      <= 6'h00;
               lng_reg    <= 6'h00;
               synced_reg <= 1'b0;
               bit_start  <= 1'b1;
            end else begin
               q_reg <= q_reg + 6'h01;
            end
         end
         // After the tick so that an edge on a tick cycle is not lost
         if (rx_s3_reg && !rx_s2_reg && !synced_reg) begin
            edge_pend_reg <= 1'b1;
         end
      end
   end

   property p_active;
      @(posedge clk) disable iff (!nrst)
      (run && !boff_reg && 32'(cnt_reg) < can_chan_pkg::WARN_LEVEL)
         |=> state_reg == can_chan_pkg::ST_ACTIVE;
   endproperty
   a_active: assert property (p_active) else $error("active state not reported");

   property p_warn;
      @(posedge clk) disable iff (!nrst)
      (run && !boff_reg && cnt_reg >= 9'd96 && cnt_reg < 9'd128)
         |=> chan_state == 5'h04;
   endproperty
   a_warn: assert property (p_warn) else $error("warning state not reported");

   property p_passive;
      @(posedge clk) disable iff (!nrst)
      (run && !boff_reg && cnt_reg >= 9'd128 && cnt_reg <= 9'd255)
         |=> state_reg == can_chan_pkg::ST_PASSIVE;
   endproperty
   a_passive: assert property (p_passive) else $error("passive state not reported");

   property p_busoff;
      @(posedge clk) disable iff (!nrst)
      (run && cnt_reg > 9'd255 && !chan_rst_reg)
         |=> state_reg == can_chan_pkg::ST_BUSOFF ##1 can_tx;
   endproperty
   a_busoff: assert property (p_busoff) else $error("bus-off not entered");

   property p_listen;
      @(posedge clk) disable iff (!nrst)
      listen_reg |=> can_tx;
   endproperty
   a_listen: assert property (p_listen) else $error("listen-only drove the bus");

   property p_reject;
      @(posedge clk) disable iff (!nrst)
      (tim_wr && !tim_good) |=> $stable(tim_reg) && int_sts_reg[3];
   endproperty
   a_reject: assert property (p_reject) else $error("bad timing applied");

   property p_tim_legal;
      @(posedge clk) disable iff (!nrst)
      ts1 >= 6'd4 && ts2 >= 6'd2 && ts2 <= 6'd8 && sjw >= 6'd1 && sjw <= 6'd4 &&
      brp_v >= 9'd1 && brp_v <= 9'd256;
   endproperty
   a_tim_legal: assert property (p_tim_legal) else $error("timing out of range");

   property p_sample;
      @(posedge clk) disable iff (!nrst || eng_clr)
      (tq_tick && q_reg == ts1 + lng_reg && !edge_pend_reg)
         |=> sample_pulse && rx_bit == $past(rx_s2_reg);
   endproperty
   a_sample: assert property (p_sample) else $error("sample point missed");

   property p_sjw;
      @(posedge clk) disable iff (!nrst)
      lng_reg <= sjw || tim_apply_reg;
   endproperty
   a_sjw: assert property (p_sjw) else $error("resync beyond jump width");

   property p_chan_rst;
      @(posedge clk) disable iff (!nrst)
      chan_rst_reg |=> cnt_reg == 9'h000 && !boff_reg && q_reg == 6'h00;
   endproperty
   a_chan_rst: assert property (p_chan_rst) else $error("channel reset incomplete");

   property p_inactive;
      @(posedge clk) disable iff (!nrst)
      !run |=> chan_state == 5'h01 && can_tx;
   endproperty
   a_inactive: assert property (p_inactive) else $error("inactive not reported");

endmodule : can_chan_ctrl
`default_nettype wire

// File: common/can_chan_pkg.sv
// Notes on behaviour
// - Enabled channel with error count below 96 reports error-active.
// - Error count reaching 96 through bus errors reports error-warning.
// - Error count reaching 128 reports error-passive.
// - Error count above 255 enters bus-off, leaves the bus, reports bus-off.
// - Listen-only sends no frames and never drives acknowledge bits.
// - Prescaler divides controller clock into quanta, settings 1 to 256.
// - Phase segment 1 takes 1 to 8 quanta, phase segment 2 takes 2 to 8.
// - Propagation segment takes 1 to 8 quanta.
// - Each bit opens with a one-quantum synchronisation segment.
// - Time segment 1 is phase 1 plus propagation; sum below 4 is invalid.
// - Time segment 2 equals phase segment 2.
// - Bus level is sampled at the end of time segment 1.
// - Jump width 1 to 4 bounds resync changes, not the nominal rate.
// - Timing giving a rate outside 40k to 1M bit/s is rejected, not applied.
// - Each channel can be switched on or off; off or asleep reports inactive.
// - A command resets the channel controller to its initial state; the reset bit clears only error count, bus-off and bit timing.
`default_nettype none
package can_chan_pkg;
   localparam int CLK_HZ       = 125_000_000;
   localparam int RATE_MIN_BPS = 40_000;
   localparam int RATE_MAX_BPS = 1_000_000;
   localparam int BIT_CYC_MIN  = CLK_HZ / RATE_MAX_BPS;
   localparam int BIT_CYC_MAX  = CLK_HZ / RATE_MIN_BPS;
   localparam int TS1_MIN      = 4;
   localparam int WARN_LEVEL   = 96;
   localparam int PASSIVE_LEVEL = 128;
   localparam int BUSOFF_ABOVE = 255;
   localparam int ERR_STEP     = 8;

   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_TIMING  = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_INT_STS = 8'h0c;
   localparam logic [7:0] OFS_INT_MSK = 8'h10;

   localparam int CTRL_EN     = 0;
   localparam int CTRL_LISTEN = 1;
   localparam int CTRL_RST    = 2;
   localparam int CTRL_SLEEP  = 3;

   localparam int TIM_BRP  = 0;
   localparam int TIM_PROP = 12;
   localparam int TIM_PH1  = 16;
   localparam int TIM_PH2  = 20;
   localparam int TIM_SJW  = 24;
   localparam logic [31:0] TIM_MASK  = 32'h07ff_f1ff;
   // 500 kbit/s: 25 clocks per quantum, 1+4+3+2 quanta
   localparam logic [31:0] TIM_RESET = 32'h0123_4019;

   localparam int STS_STATE = 0;
   localparam int STS_CNT   = 8;

   localparam int INT_WARN   = 0;
   localparam int INT_PASS   = 1;
   localparam int INT_BOFF   = 2;
   localparam int INT_REJECT = 3;
   localparam int INT_W      = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [4:0] {
      ST_INACTIVE = 5'h01,
      ST_ACTIVE   = 5'h02,
      ST_WARNING  = 5'h04,
      ST_PASSIVE  = 5'h08,
      ST_BUSOFF   = 5'h10
   } chan_state_e;
endpackage : can_chan_pkg
`default_nettype wire

// File: test/can_node_model.sv
`timescale 1ns/100ps
`default_nettype none
module can_node_model (
   // Bus side
   input  wire logic can_tx,
   output var  logic can_rx,
   input  wire logic drive_dom
);
   // Wired-AND with pull-up: a released bus reads recessive
   assign can_rx = can_tx & ~drive_dom;
endmodule : can_node_model
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
   logic        arready, rvalid, rready, tx_bit, ack_drive, err_event, ok_event, rx_bit;
   logic        sample_pulse, bit_start, irq, can_rx, can_tx, drive_dom;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [4:0]  chan_state;
   int          err_total, check_count;
   can_chan_ctrl dut_u (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .tx_bit, .ack_drive, .err_event, .ok_event, .rx_bit, .sample_pulse,
      .bit_start, .chan_state, .irq, .can_rx, .can_tx);
   can_node_model node_u (.can_tx, .can_rx, .drive_dom);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish();
      if (err_total == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0,
                     input logic [3:0] s = 4'hf);
      awaddr <= a;
      wdata  <= d;
      wstrb  <= s;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      chk("bresp", bresp, e);
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = 2'h0);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      chk("rresp,rdata", {rresp, rdata}, {e, x});
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd
   // Events are one-cycle pulses with a gap so each one counts once
   task automatic ev(input int n, input logic good);
      repeat (n) begin
         {err_event, ok_event} <= {~good, good};
         @(posedge clk);
         {err_event, ok_event} <= 2'h0;
         @(posedge clk);
      end
      repeat (3) @(posedge clk);
   endtask : ev
   task automatic st(input logic [4:0] s);
      chk("chan_state", chan_state, s);
   endtask : st
   task automatic tx(input logic t, input logic a, input logic x);
      {tx_bit, ack_drive} <= {t, a};
      repeat (3) @(posedge clk);
      chk("can_tx", can_tx, x);
   endtask : tx
   task automatic per(input int x);
      int n = 0;
      int b = 0;
      @(posedge clk iff sample_pulse === 1'b1);
      do begin
         @(posedge clk);
         n++;
         if (bit_start === 1'b1) b++;
      end while (sample_pulse !== 1'b1);
      chk("bit period", n, x);
      chk("bit starts", b, 1);
   endtask : per
   task automatic t_reset();
      rd(8'h00, 32'h0);
      rd(8'h04, can_chan_pkg::TIM_RESET);
      rd(8'h08, 32'h1);
      rd(8'h20, 32'h0, 2'h2);
      wr(8'h20, 32'h1, 2'h2);
   endtask : t_reset
   task automatic t_link();
      wr(8'h00, 32'h1);
      st(5'h02);
      tx(0, 0, 0);
      tx(1, 1, 0);
      wr(8'h00, 32'h3);
      tx(0, 0, 1);
      tx(1, 1, 1);
      wr(8'h00, 32'h9);
      st(5'h01);
      wr(8'h00, 32'h1);
   endtask : t_link
   task automatic t_err();
      ev(11, 0);
      st(5'h02);
      ev(1, 0);
      st(5'h04);
      chk("irq", irq, 1'b0);
      wr(8'h10, 32'hf);
      chk("irq", irq, 1'b1);
      ev(1, 1);
      st(5'h02);
      ev(5, 0);
      st(5'h08);
      ev(16, 0);
      st(5'h10);
      tx(0, 0, 1);
      tx(1, 0, 1);
      ev(1, 1);
      rd(8'h08, 32'h0001_0710);
      rd(8'h0c, 32'h7);
      wr(8'h0c, 32'h7);
      chk("irq", irq, 1'b0);
      wr(8'h00, 32'h5);
      rd(8'h08, 32'h2);
   endtask : t_err
   task automatic t_timing();
      int p [16][5] = '{'{0,2,2,2,1}, '{257,2,2,2,1}, '{25,0,4,2,1}, '{25,4,0,2,1},
         '{25,2,2,1,1}, '{25,2,2,2,0}, '{25,2,2,2,5}, '{25,1,2,2,1}, '{25,9,1,2,1},
         '{25,1,9,2,1}, '{25,2,2,9,1}, '{1,1,3,2,1}, '{256,8,8,8,4},
         '{256,1,3,2,4}, '{5,8,8,8,1}, '{25,2,2,2,1}};
      logic [31:0] t;
      logic [31:0] cur;
      bit          ok;
      wr(8'h04, 32'hffff_ff32, 2'h0, 4'h1);
      cur = 32'h0123_4032;
      rd(8'h04, cur);
      per(500);
      for (int i = 0; i < 16; i++) begin
         ok = (i > 12);
         t = {5'h0, p[i][4][2:0], p[i][3][3:0], p[i][2][3:0], p[i][1][3:0], 3'h0,
              p[i][0][8:0]};
         wr(8'h04, t);
         if (ok) cur = t;
         rd(8'h04, cur);
         rd(8'h0c, ok ? 32'h0 : 32'h8);
         chk("irq", irq, !ok);
         wr(8'h0c, 32'h8);
         if (ok) per(p[i][0] * (p[i][1] + p[i][2] + p[i][3] + 1));
      end
      drive_dom <= 1'b1;
      repeat (2) @(posedge clk iff sample_pulse === 1'b1);
      chk("rx_bit", rx_bit, 1'b0);
      drive_dom <= 1'b0;
      repeat (2) @(posedge clk iff sample_pulse === 1'b1);
      chk("rx_bit", rx_bit, 1'b1);
   endtask : t_timing
   initial begin
      {nrst, awvalid, wvalid, bready, arvalid, rready, err_event, ok_event, ack_drive} = '0;
      {wstrb, awaddr, araddr, wdata, drive_dom} = '0;
      tx_bit = 1'b1;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset();
      t_link();
      t_err();
      t_timing();
      tally_and_finish();
   end
   // Run needs under 10k cycles; allow 25k before declaring a hang
   initial begin
      #200_000;
      err_total++;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
